// ### pkg/eets_cfg.svh
`ifndef EETS_CFG_SVH
`define EETS_CFG_SVH

// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define EETS_BYTE_W 8
`define EETS_SYNC_W 2
`define EETS_ZERO_BYTE 8'h00
`define EETS_ONE_BYTE 8'h01
`define EETS_COUNT_STEP 8'h01

// ---------------------------------------------------------------
// bcd limits of the time counters
// ---------------------------------------------------------------
`define EETS_HUND_MAX 8'h99
`define EETS_SEC_MAX 8'h59
`define EETS_MIN_MAX 8'h59
`define EETS_HOUR_MAX 8'h23
`define EETS_MONTH_MAX 8'h12
`define EETS_YEAR_MAX 8'h99
`define EETS_MONTH_FEB 8'h02
`define EETS_DAYS_28 8'h28
`define EETS_DAYS_29 8'h29
`define EETS_DAYS_30 8'h30
`define EETS_DAYS_31 8'h31

// ---------------------------------------------------------------
// synchroniser bit positions and power-on settle count
// ---------------------------------------------------------------
`define EETS_SYNC_EVENT 0
`define EETS_SYNC_BACKUP 1
`define EETS_POR_SETTLE 3'h4

`endif

// ### pkg/eets_pkg.sv
package eets_pkg;

    // ---------------------------------------------------------------
    // time snapshot, all fields bcd
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
        logic [7:0] hund;
    } eets_time_t;

    // ---------------------------------------------------------------
    // field select of the time write port
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        EETS_SEL_HUND = 3'h0,
        EETS_SEL_SEC = 3'h1,
        EETS_SEL_MIN = 3'h2,
        EETS_SEL_HOUR = 3'h3,
        EETS_SEL_DATE = 3'h4,
        EETS_SEL_MONTH = 3'h5,
        EETS_SEL_YEAR = 3'h6,
        EETS_SEL_NONE = 3'h7
    } eets_sel_t;

    // ---------------------------------------------------------------
    // power-on check state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        EETS_POR_SETTLING = 2'h0,
        EETS_POR_DONE = 2'h1
    } eets_por_t;

endpackage

// ### pkg/eets_sync_if.sv
`timescale 1ns/1ps
`include "eets_cfg.svh"

interface eets_sync_if;
    logic [`EETS_SYNC_W-1:0] raw;
    logic [`EETS_SYNC_W-1:0] level;

    modport filter (
        input raw,
        output level
    );

    modport core (
        output raw,
        input level
    );
endinterface

// ### rtl/eets_pin_filter.sv
`timescale 1ns/1ps
`include "eets_cfg.svh"

module eets_pin_filter (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins in, filtered levels out
    eets_sync_if.filter sync
);

    // ---------------------------------------------------------------
    // three-stage synchroniser, level taken once stages two and three agree
    // ---------------------------------------------------------------
    logic [`EETS_SYNC_W-1:0] stage1;
    logic [`EETS_SYNC_W-1:0] stage2;
    logic [`EETS_SYNC_W-1:0] stage3;
    logic [`EETS_SYNC_W-1:0] level;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= sync.raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            level <= '0;
        end else begin
            for (int i = 0; i < `EETS_SYNC_W; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    end

    assign sync.level = level;

endmodule

// ### rtl/eets_top.sv
`timescale 1ns/1ps
`include "eets_cfg.svh"

// Function
// - event copies clock and calendar into stamps
// - overwrite off: only first event is recorded
// - overwrite on: every event rewrites time fields
// - every event outside host stamp reads increments the event counter
// - clear write zeroes all eight stamp registers
// - each written one clears once, held one not
// - stamp clear leaves the event flag alone
// - reset clears stamps only when pin high
// - counter zero alone enables a first capture
// - sync bit: stamp, zero hundredths, drop bit
// - seconds write zeroes the hundredths counter
// - no extra second tick from stop/write/sync
// - stop halts ticks, zeroes hundredths, events work
// - capture blocked during host stamp reads
// - no detection in backup supply state
// - event sets flag, interrupt when enabled
module eets_top
    import eets_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // event pin and power state
    input wire logic external_event_input,
    input wire logic backup_supply_state,
    // configuration levels
    input wire logic event_overwrite_select,
    input wire logic external_event_irq_enable,
    input wire logic time_stop,
    input wire logic stamp_read_active,
    // control bit writes
    input wire logic event_stamp_clear_wr,
    input wire logic event_stamp_clear_wdata,
    input wire logic event_time_sync_wr,
    input wire logic event_time_sync_wdata,
    input wire logic event_flag_clear,
    // time write port and timebase
    input wire logic time_wr,
    input wire eets_sel_t time_wr_sel,
    input wire logic [7:0] time_wr_data,
    input wire logic tick_100hz,
    // status and data
    output logic event_stamp_clear,
    output logic event_time_sync,
    output logic external_event_flag,
    output logic irq_n,
    output eets_time_t time_now,
    output eets_time_t stamp,
    output logic [7:0] event_capture_counter
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    eets_sync_if sync_bus ();

    assign sync_bus.raw = {backup_supply_state, external_event_input};

    eets_pin_filter u_filter (
        .clk(clk),
        .rst_n(rst_n),
        .sync(sync_bus.filter)
    );

    logic evt_level;
    logic backup_level;
    logic evt_prev;
    logic event_seen;
    logic capture_ok;
    logic clear_pulse;
    logic sync_event;
    logic por_clear;
    eets_por_t por_state;
    logic [2:0] por_count;
    eets_time_t next_time;

    assign evt_level = sync_bus.level[`EETS_SYNC_EVENT];
    assign backup_level = sync_bus.level[`EETS_SYNC_BACKUP];

    // ---------------------------------------------------------------
    // bcd helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] == 4'h9) begin
            r = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            r = {v[7:4], 4'(v[3:0] + 4'h1)};
        end
        return r;
    endfunction

    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        logic [7:0] d;
        leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8))
            || (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
        d = `EETS_DAYS_31;
        if (m == `EETS_MONTH_FEB) begin
            d = leap ? `EETS_DAYS_29 : `EETS_DAYS_28;
        end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
            d = `EETS_DAYS_30;
        end
        return d;
    endfunction

    // ---------------------------------------------------------------
    // time counters
    // ---------------------------------------------------------------
    always_comb begin
        next_time = time_now;
        // only the hundredths wrap moves the seconds
        if (tick_100hz && !time_stop) begin
            if (time_now.hund == `EETS_HUND_MAX) begin
                next_time.hund = `EETS_ZERO_BYTE;
                if (time_now.second == `EETS_SEC_MAX) begin
                    next_time.second = `EETS_ZERO_BYTE;
                    if (time_now.minute == `EETS_MIN_MAX) begin
                        next_time.minute = `EETS_ZERO_BYTE;
                        if (time_now.hour == `EETS_HOUR_MAX) begin
                            next_time.hour = `EETS_ZERO_BYTE;
                            if (time_now.date == month_days(time_now.month, time_now.year)) begin
                                next_time.date = `EETS_ONE_BYTE;
                                if (time_now.month == `EETS_MONTH_MAX) begin
                                    next_time.month = `EETS_ONE_BYTE;
                                    if (time_now.year == `EETS_YEAR_MAX) begin
                                        next_time.year = `EETS_ZERO_BYTE;
                                    end else begin
                                        next_time.year = bcd_inc(time_now.year);
                                    end
                                end else begin
                                    next_time.month = bcd_inc(time_now.month);
                                end
                            end else begin
                                next_time.date = bcd_inc(time_now.date);
                            end
                        end else begin
                            next_time.hour = bcd_inc(time_now.hour);
                        end
                    end else begin
                        next_time.minute = bcd_inc(time_now.minute);
                    end
                end else begin
                    next_time.second = bcd_inc(time_now.second);
                end
            end else begin
                next_time.hund = bcd_inc(time_now.hund);
            end
        end
        if (time_stop) begin
            next_time.hund = `EETS_ZERO_BYTE;
        end
        if (sync_event) begin
            next_time.hund = `EETS_ZERO_BYTE;
        end
        if (time_wr) begin
            case (time_wr_sel)
                EETS_SEL_HUND: next_time.hund = time_wr_data;
                EETS_SEL_SEC: begin
                    next_time.second = time_wr_data;
                    next_time.hund = `EETS_ZERO_BYTE;
                end
                EETS_SEL_MIN: next_time.minute = time_wr_data;
                EETS_SEL_HOUR: next_time.hour = time_wr_data;
                EETS_SEL_DATE: next_time.date = time_wr_data;
                EETS_SEL_MONTH: next_time.month = time_wr_data;
                EETS_SEL_YEAR: next_time.year = time_wr_data;
                default: next_time = next_time;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            time_now <= '{year: `EETS_ZERO_BYTE, month: `EETS_ONE_BYTE,
                          date: `EETS_ONE_BYTE, hour: `EETS_ZERO_BYTE,
                          minute: `EETS_ZERO_BYTE, second: `EETS_ZERO_BYTE,
                          hund: `EETS_ZERO_BYTE};
        end else begin
            time_now <= next_time;
        end
    end

    // ---------------------------------------------------------------
    // power-on pin check
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            por_state <= EETS_POR_SETTLING;
            por_count <= 3'h0;
        end else begin
            case (por_state)
                EETS_POR_SETTLING: begin
                    por_count <= 3'(por_count + 3'h1);
                    if (por_count == `EETS_POR_SETTLE) begin
                        por_state <= EETS_POR_DONE;
                    end
                end
                EETS_POR_DONE: por_state <= EETS_POR_DONE;
                default: por_state <= EETS_POR_DONE;
            endcase
        end
    end

    assign por_clear = (por_state == EETS_POR_SETTLING)
        && (por_count == `EETS_POR_SETTLE) && evt_level;

    // ---------------------------------------------------------------
    // event detection
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            evt_prev <= 1'b0;
        end else begin
            evt_prev <= evt_level;
        end
    end

    assign event_seen = evt_level && !evt_prev && (por_state == EETS_POR_DONE)
        && !backup_level;
    assign capture_ok = event_seen && !stamp_read_active;
    assign sync_event = event_seen && event_time_sync;
    assign clear_pulse = event_stamp_clear_wr && event_stamp_clear_wdata;

    // ---------------------------------------------------------------
    // stamp clear bit and sync bit
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            event_stamp_clear <= 1'b0;
        end else if (event_stamp_clear_wr) begin
            event_stamp_clear <= event_stamp_clear_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            event_time_sync <= 1'b0;
        end else if (sync_event) begin
            event_time_sync <= 1'b0;
        end else if (event_time_sync_wr) begin
            event_time_sync <= event_time_sync_wdata;
        end
    end

    // ---------------------------------------------------------------
    // stamp registers, kept through reset unless the pin is high
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (clear_pulse || por_clear) begin
            stamp <= '0;
            event_capture_counter <= `EETS_ZERO_BYTE;
        end else if (capture_ok) begin
            event_capture_counter <= 8'(event_capture_counter + `EETS_COUNT_STEP);
            if (event_overwrite_select || event_capture_counter == `EETS_ZERO_BYTE) begin
                stamp <= time_now;
            end
        end
    end

    // ---------------------------------------------------------------
    // flag and interrupt
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            external_event_flag <= 1'b0;
        end else if (event_seen) begin
            external_event_flag <= 1'b1;
        end else if (event_flag_clear) begin
            external_event_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !(external_event_flag && external_event_irq_enable);
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_FIRST_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
        capture_ok && !clear_pulse && event_capture_counter == `EETS_ZERO_BYTE
        |=> stamp == $past(time_now))
        else $error("first event not captured");

    AST_FIRST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        capture_ok && !clear_pulse && !event_overwrite_select
        && event_capture_counter != `EETS_ZERO_BYTE |=> $stable(stamp))
        else $error("stamp changed in first-event mode");

    AST_OVERWRITE: assert property (@(posedge clk) disable iff (!rst_n)
        capture_ok && !clear_pulse && event_overwrite_select
        |=> stamp == $past(time_now))
        else $error("stamp not overwritten");

    AST_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
        capture_ok && !clear_pulse && !por_clear
        |=> event_capture_counter == 8'($past(event_capture_counter) + 8'h01))
        else $error("event counter did not step");

    AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        clear_pulse |=> event_capture_counter == 8'h00 && stamp == '0)
        else $error("stamp set not cleared");

    AST_FLAG_KEPT: assert property (@(posedge clk) disable iff (!rst_n)
        clear_pulse && external_event_flag && !event_flag_clear |=> external_event_flag)
        else $error("stamp clear touched the flag");

    AST_SYNC: assert property (@(posedge clk) disable iff (!rst_n)
        sync_event && !time_wr |=> time_now.hund == 8'h00 && !event_time_sync)
        else $error("event sync failed");

    AST_SEC_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        time_wr && time_wr_sel == EETS_SEL_SEC |=> time_now.hund == 8'h00)
        else $error("seconds write kept hundredths");

    AST_STOP: assert property (@(posedge clk) disable iff (!rst_n)
        time_stop && !(time_wr && (time_wr_sel == EETS_SEL_HUND || time_wr_sel == EETS_SEL_SEC))
        |=> time_now.hund == 8'h00 && time_now.second == $past(time_now.second))
        else $error("time ran while stopped");

    AST_READ_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
        stamp_read_active && !clear_pulse && !por_clear
        |=> $stable(event_capture_counter) && $stable(stamp))
        else $error("capture during stamp read");

    AST_BACKUP: assert property (@(posedge clk) disable iff (!rst_n)
        backup_level && !external_event_flag |=> !external_event_flag)
        else $error("event seen in backup state");

    AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
        event_seen && external_event_irq_enable |=> ##1 !irq_n)
        else $error("interrupt not raised");

endmodule

// ### tb/eets_evt_src.sv
`timescale 1ns/1ps

module eets_evt_src (
    // clock
    input wire logic clk,
    // event pin
    output logic pin
);
    // ---------------------------------------------------------------
    // event pin source
    // ---------------------------------------------------------------
    // pin idles high so the power-on check clears the stamps
    initial begin
        pin = 1'b1;
    end

    // each level is held six cycles, well past the filter length
    task automatic fire();
        @(posedge clk);
        #1 pin = 1'b0;
        repeat (6) @(posedge clk);
        #1 pin = 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule

// ### tb/external_event_timestamp_tb_top.sv
`timescale 1ns/1ps

`define CHK(nm, e, g) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) begin \
            miscompares++; \
            $display("BAD %s exp %h got %h", nm, e, g); \
        end \
    end

module external_event_timestamp_tb_top
    import eets_pkg::*;
;
    logic clk, rst_n, external_event_input, backup_supply_state;
    logic event_overwrite_select, external_event_irq_enable, time_stop;
    logic stamp_read_active, event_stamp_clear_wr, event_stamp_clear_wdata;
    logic event_time_sync_wr, event_time_sync_wdata, event_flag_clear;
    logic time_wr, tick_100hz, tick_man, tick_auto, mon_on;
    eets_sel_t time_wr_sel;
    logic [7:0] time_wr_data, event_capture_counter, exp_cnt, prev_cnt;
    logic event_stamp_clear, event_time_sync, external_event_flag, irq_n;
    eets_time_t time_now, stamp, cur, exp_stamp;
    logic [63:0] notes[$];
    logic [63:0] note;
    int miscompares, cmp_count;

    eets_evt_src src (.clk(clk), .pin(external_event_input));

    eets_top dut (
        .clk,
        .rst_n,
        .external_event_input,
        .backup_supply_state,
        .event_overwrite_select,
        .external_event_irq_enable,
        .time_stop,
        .stamp_read_active,
        .event_stamp_clear_wr,
        .event_stamp_clear_wdata,
        .event_time_sync_wr,
        .event_time_sync_wdata,
        .event_flag_clear,
        .time_wr,
        .time_wr_sel,
        .time_wr_data,
        .tick_100hz,
        .event_stamp_clear,
        .event_time_sync,
        .external_event_flag,
        .irq_n,
        .time_now,
        .stamp,
        .event_capture_counter
    );

    // ---------------------------------------------------------------
    // clock, ticks and result monitor
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        tick_100hz <= tick_man | (tick_auto && $urandom_range(3) == 0);
    end

    always @(negedge clk) begin
        if (mon_on && event_capture_counter !== prev_cnt) begin
            if (notes.size() == 0) begin
                `CHK("unexpected count", prev_cnt, event_capture_counter)
            end else begin
                note = notes.pop_front();
                `CHK("stamp", note, {stamp, event_capture_counter})
            end
        end
        prev_cnt = event_capture_counter;
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic drain();
        for (int i = 0; i < 20; i++) begin
            if (notes.size() == 0) begin
                return;
            end
            step(1);
        end
        miscompares++;
        end_of_test();
    endtask

    function automatic logic [7:0] bcd(int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction

    function automatic eets_time_t rand_time();
        eets_time_t t;
        t.year = bcd($urandom_range(99));
        t.month = bcd($urandom_range(12, 1));
        t.date = bcd($urandom_range(28, 1));
        t.hour = bcd($urandom_range(23));
        t.minute = bcd($urandom_range(59));
        t.second = bcd($urandom_range(59));
        t.hund = 8'h00;
        return t;
    endfunction

    task automatic wr_time(eets_time_t t);
        cur = t;
        time_wr = 1'b1;
        for (int k = 1; k < 7; k++) begin
            time_wr_sel = eets_sel_t'(k);
            time_wr_data = t[k*8 +: 8];
            step(1);
        end
        time_wr = 1'b0;
        time_wr_sel = EETS_SEL_NONE;
        step(1);
        `CHK("time write", cur, time_now)
    endtask

    task automatic tick3();
        tick_man = 1'b1;
        step(3);
        tick_man = 1'b0;
        step(1);
        cur.hund = 8'h03;
        `CHK("hund run", cur, time_now)
    endtask

    // counts: the event reaches the counter, and the stamp when first or in overwrite mode
    task automatic ev(logic counts);
        if (counts) begin
            if (exp_cnt === 8'h00 || event_overwrite_select) begin
                exp_stamp = cur;
            end
            exp_cnt = exp_cnt + 8'h01;
            notes.push_back({exp_stamp, exp_cnt});
        end
        src.fire();
        drain();
    endtask

    task automatic clr();
        if (exp_cnt !== 8'h00) begin
            notes.push_back(64'h0);
        end
        exp_cnt = 8'h00;
        exp_stamp = '0;
        event_stamp_clear_wr = 1'b1;
        event_stamp_clear_wdata = 1'b1;
        step(1);
        event_stamp_clear_wr = 1'b0;
        drain();
    endtask

    task automatic flag_clr();
        event_flag_clear = 1'b1;
        step(1);
        event_flag_clear = 1'b0;
        step(2);
        `CHK("flag clear", 2'b01, {external_event_flag, irq_n})
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(17));
        {backup_supply_state, event_overwrite_select, external_event_irq_enable} = '0;
        {stamp_read_active, event_stamp_clear_wr, event_stamp_clear_wdata} = '0;
        {event_time_sync_wr, event_time_sync_wdata, event_flag_clear} = '0;
        {time_wr, tick_man, rst_n, mon_on, miscompares, cmp_count} = '0;
        {time_wr_data, exp_cnt, exp_stamp} = '0;
        time_wr_sel = EETS_SEL_NONE;
        time_stop = 1'b1;
        tick_auto = 1'b1;
        step(5);
        rst_n = 1'b1;
        step(8);
        `CHK("power-on stamps", 64'h0, {stamp, event_capture_counter})
        mon_on = 1'b1;
        // host setup: irq off, first-event mode, flag clear, stamp clear
        flag_clr();
        clr();
        wr_time(rand_time());
        ev(1'b1);
        `CHK("flag irq off", 2'b11, {external_event_flag, irq_n})
        wr_time(rand_time());
        ev(1'b1);
        event_overwrite_select = 1'b1;
        external_event_irq_enable = 1'b1;
        ev(1'b1);
        `CHK("irq on", 1'b0, irq_n)
        stamp_read_active = 1'b1;
        ev(1'b0);
        stamp_read_active = 1'b0;
        `CHK("read blocked", 8'h03, event_capture_counter)
        event_overwrite_select = 1'b0;
        clr();
        `CHK("flag kept", 1'b1, external_event_flag)
        ev(1'b1);
        clr();
        ev(1'b1);
        ev(1'b1);
        `CHK("clear bit held", 1'b1, event_stamp_clear)
        flag_clr();
        backup_supply_state = 1'b1;
        ev(1'b0);
        `CHK("backup", 9'h002, {external_event_flag, event_capture_counter})
        backup_supply_state = 1'b0;
        wr_time(rand_time());
        repeat (255) ev(1'b1);
        `CHK("stopped time", cur, time_now)
        tick_auto = 1'b0;
        step(1);
        time_stop = 1'b0;
        tick3();
        wr_time(rand_time());
        tick3();
        event_time_sync_wr = 1'b1;
        event_time_sync_wdata = 1'b1;
        step(1);
        event_time_sync_wr = 1'b0;
        event_overwrite_select = 1'b1;
        ev(1'b1);
        cur.hund = 8'h00;
        `CHK("sync time", {1'b0, cur}, {event_time_sync, time_now})
        end_of_test();
    end
endmodule
